/* File: logic/acs_chain_sequencer.sv */
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module acs_chain_sequencer
    import acs_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Cross trigger unit
    input wire logic trig_req,
    input wire logic [CHW-1:0] trig_chan,
    // Converter core
    output logic conv_start,
    output logic conv_abort,
    output logic [CHW-1:0] conv_chan,
    input wire logic core_sampling,
    input wire logic core_done,
    input wire logic [RESW-1:0] core_data
);

    // ****************************************
    // Helper functions
    // ****************************************

    // Lowest set channel of a mask, mask order
    function automatic logic [CHW-1:0] first_ch(input logic [NCH-1:0] m);
        logic [CHW-1:0] r;
        r = '0;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (m[i])
            begin
                r = CHW'(i);
            end
        end
        return r;
    endfunction : first_ch

    // One-hot bit of a channel
    function automatic logic [NCH-1:0] ch_bit(input logic [CHW-1:0] c);
        logic [NCH-1:0] r;
        r = '0;
        r[c] = 1'b1;
        return r;
    endfunction : ch_bit

    // ****************************************
    // Declarations
    // ****************************************
    acs_state_t state_reg;                  // Sequencer state
    acs_kind_t kind_reg;                    // Chain owning current channel
    logic [CHW-1:0] cur_reg;                // Current channel
    logic scan_reg;                         // Scan mode
    logic normal_chain_running_reg;                       // Normal start command bit
    logic cancel_reg;                       // Chain cancel command bit
    logic link_en_reg;                      // Trigger unit link enable
    logic [NCH-1:0] nmask_reg;              // Normal channel mask
    logic [NCH-1:0] jmask_reg;              // Injected channel mask
    logic [NCH-1:0] pend_reg;               // Channel done pending bits
    logic [NCH-1:0] ntodo_reg;              // Normal channels still to convert
    logic [NCH-1:0] jtodo_reg;              // Injected channels still to convert
    logic tpend_reg;                        // Trigger unit request pending
    logic [CHW-1:0] tchan_reg;              // Trigger unit channel
    logic [NFLAG-1:0] flag_reg;             // Interrupt flags
    logic [NFLAG-1:0] imask_reg;            // Interrupt mask
    logic [31:0] prdata_reg;                // Registered read data
    logic res_sel_reg;                      // Read targets result store
    logic [RESW-1:0] mem_rdata;             // Result store read data
    logic conv_start_reg;                   // Start pulse to core
    logic conv_abort_reg;                   // Abort pulse to core

    // Bus decode
    logic wr_acc;
    logic setup;
    logic is_res;
    logic mapped;
    logic cfg_wr;
    logic normal_chain_running_wr;
    logic injected_chain_running_wr;
    logic abort_wr;

    // Sequencer events
    logic busy;
    logic done_ev;
    logic swab_ev;
    logic restart_ev;
    logic cancel_cur;
    logic preempt;
    logic [NCH-1:0] cur_bit;
    logic n_last;
    logic j_last;
    logic n_end;
    logic j_end;
    logic t_end;
    logic [NFLAG-1:0] flag_set;
    logic nrun;

    // ****************************************
    // APB decode
    // ****************************************

    // Writes complete in the access cycle
    assign wr_acc = psel && penable && pwrite;
    assign setup = psel && !penable;
    assign is_res = (paddr >= OFS_RESULT) && (paddr < OFS_RESULT + RESULT_SPAN)
                    && (paddr[1:0] == 2'h0);
    assign mapped = is_res || (paddr == OFS_MAIN_CONFIG) || (paddr == OFS_MAIN_STATUS)
                    || (paddr == OFS_INT_FLAG) || (paddr == OFS_INT_MASK)
                    || (paddr == OFS_NORM_MASK) || (paddr == OFS_INJ_MASK)
                    || (paddr == OFS_DONE_PEND);
    assign cfg_wr = wr_acc && (paddr == OFS_MAIN_CONFIG);
    assign normal_chain_running_wr = cfg_wr && pwdata[CFG_NORMAL_CHAIN_RUNNING];
    assign injected_chain_running_wr = cfg_wr && pwdata[CFG_INJECTED_CHAIN_RUNNING];
    assign abort_wr = cfg_wr && pwdata[CFG_ABORT];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ****************************************
    // Sequencer event terms
    // ****************************************
    assign busy = (state_reg == ST_SAMPLE) || (state_reg == ST_CONV);
    assign cur_bit = ch_bit(cur_reg);
    assign done_ev = busy && core_done;
    // Software abort drops the channel in flight
    assign swab_ev = busy && abort_wr && !done_ev;
    // One-shot normal start during a normal chain restarts it
    assign restart_ev = busy && normal_chain_running_wr && !scan_reg && (kind_reg == K_NORM);
    // Cancel drops the injected channel in flight
    assign cancel_cur = busy && cancel_reg && (kind_reg == K_INJ);
    // Preemption cases, any phase of the channel
    always_comb
    begin
        preempt = 1'b0;
        if (busy && !done_ev)
        begin
            if (kind_reg == K_NORM)
            begin
                preempt = (|jtodo_reg) || tpend_reg;
            end
            else if (kind_reg == K_INJ)
            begin
                preempt = tpend_reg;
            end
        end
    end
    assign n_last = (ntodo_reg & ~cur_bit) == '0;
    assign j_last = (jtodo_reg & ~cur_bit) == '0;
    // Chain end: last channel completed or dropped; a trigger conversion ends only on completion
    assign n_end = (kind_reg == K_NORM) && n_last && (done_ev || swab_ev) && !restart_ev;
    assign j_end = (kind_reg == K_INJ) && j_last && (done_ev || swab_ev) && !cancel_reg;
    assign t_end = (kind_reg == K_TRIG) && done_ev;
    // One flag per chain end; cancel raises the injected flag
    assign flag_set = {t_end, j_end || cancel_reg, n_end};
    // Running flag: one-shot falls with the chain, scan holds while started
    assign nrun = (|ntodo_reg) || (scan_reg && normal_chain_running_reg);

    // ****************************************
    // Sequencer state machine
    // ****************************************

    // Channel launch, phase tracking and abort
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_IDLE;
            kind_reg <= K_NORM;
            cur_reg <= '0;
            conv_start_reg <= 1'b0;
            conv_abort_reg <= 1'b0;
        end
        else
        begin
            conv_start_reg <= 1'b0;
            conv_abort_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    // Priority: trigger, then injected, then normal
                    if (tpend_reg)
                    begin
                        kind_reg <= K_TRIG;
                        cur_reg <= tchan_reg;
                        conv_start_reg <= 1'b1;
                        state_reg <= ST_SAMPLE;
                    end
                    else if (|jtodo_reg)
                    begin
                        kind_reg <= K_INJ;
                        cur_reg <= first_ch(jtodo_reg);
                        conv_start_reg <= 1'b1;
                        state_reg <= ST_SAMPLE;
                    end
                    else if (|ntodo_reg)
                    begin
                        // Resume in mask order from the first unfinished one
                        kind_reg <= K_NORM;
                        cur_reg <= first_ch(ntodo_reg);
                        conv_start_reg <= 1'b1;
                        state_reg <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE, ST_CONV:
                begin
                    if (done_ev)
                    begin
                        state_reg <= ST_IDLE;
                    end
                    else if (preempt || swab_ev || restart_ev || cancel_cur)
                    begin
                        // Stop the core; restored channels stay in their chain
                        conv_abort_reg <= 1'b1;
                        state_reg <= ST_ABORT;
                    end
                    else if (state_reg == ST_SAMPLE && !core_sampling && !conv_start_reg)
                    begin
                        state_reg <= ST_CONV;
                    end
                end
                ST_ABORT:
                begin
                    // One settle cycle for the core after abort
                    state_reg <= ST_IDLE;
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign conv_start = conv_start_reg;
    assign conv_abort = conv_abort_reg;
    assign conv_chan = cur_reg;

    // ****************************************
    // Chain bookkeeping
    // ****************************************

    // Normal chain: loaded on start, bit removed when converted or dropped by software abort
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ntodo_reg <= '0;
        end
        else if (normal_chain_running_wr)
        begin
            ntodo_reg <= nmask_reg;
        end
        else if (kind_reg == K_NORM && (done_ev || swab_ev))
        begin
            if (n_last && scan_reg && normal_chain_running_reg)
            begin
                ntodo_reg <= nmask_reg;
            end
            else
            begin
                ntodo_reg <= ntodo_reg & ~cur_bit;
            end
        end
    end

    // Injected chain: cancel empties it, abort drops one channel
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            jtodo_reg <= '0;
        end
        else if (cancel_reg)
        begin
            jtodo_reg <= '0;
        end
        else if (injected_chain_running_wr)
        begin
            jtodo_reg <= jmask_reg;
        end
        else if (kind_reg == K_INJ && (done_ev || swab_ev))
        begin
            jtodo_reg <= jtodo_reg & ~cur_bit;
        end
    end

    // Trigger unit request; held while link enabled, new request wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tpend_reg <= 1'b0;
            tchan_reg <= '0;
        end
        else if (!link_en_reg)
        begin
            tpend_reg <= 1'b0;
        end
        else if (trig_req)
        begin
            tpend_reg <= 1'b1;
            tchan_reg <= trig_chan;
        end
        else if (kind_reg == K_TRIG && (done_ev || swab_ev))
        begin
            tpend_reg <= 1'b0;
        end
    end

    // Pending bits: set on conversion done, set wins over write-one-clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (done_ev && cur_reg == CHW'(i))
                begin
                    pend_reg[i] <= 1'b1;
                end
                else if (wr_acc && paddr == OFS_DONE_PEND && pwdata[i])
                begin
                    pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Result store, written at each completion
    acs_result_mem u_mem (
        .pclk(pclk),
        .we(done_ev),
        .waddr(cur_reg),
        .wdata(core_data),
        .raddr(paddr[CHW+1:2]),
        .rdata(mem_rdata)
    );

    // ****************************************
    // Configuration registers
    // ****************************************

    // Main configuration; cancel cleared by hardware once handled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_reg <= 1'b0;
            normal_chain_running_reg <= 1'b0;
            cancel_reg <= 1'b0;
            link_en_reg <= 1'b0;
        end
        else if (cfg_wr)
        begin
            scan_reg <= pwdata[CFG_SCAN];
            normal_chain_running_reg <= pwdata[CFG_NORMAL_CHAIN_RUNNING];
            cancel_reg <= pwdata[CFG_CANCEL];
            link_en_reg <= pwdata[CFG_LINK_EN];
        end
        else
        begin
            cancel_reg <= 1'b0;
            // One-shot start bit falls when the chain finishes
            if (!scan_reg && n_end)
            begin
                normal_chain_running_reg <= 1'b0;
            end
        end
    end

    // Masks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmask_reg <= '0;
            jmask_reg <= '0;
            imask_reg <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr == OFS_NORM_MASK)
            begin
                nmask_reg <= pwdata[NCH-1:0];
            end
            if (paddr == OFS_INJ_MASK)
            begin
                jmask_reg <= pwdata[NCH-1:0];
            end
            if (paddr == OFS_INT_MASK)
            begin
                imask_reg <= pwdata[NFLAG-1:0];
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************

    // Sticky flags, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < NFLAG; i++)
            begin
                if (flag_set[i])
                begin
                    flag_reg[i] <= 1'b1;
                end
                else if (wr_acc && paddr == OFS_INT_FLAG && pwdata[i])
                begin
                    flag_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Level interrupt while any unmasked flag is set
    assign irq = |(flag_reg & imask_reg);

    // ****************************************
    // Read path
    // ****************************************

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= '0;
            res_sel_reg <= 1'b0;
        end
        else if (setup)
        begin
            res_sel_reg <= is_res;
            prdata_reg <= '0;
            case (paddr)
                OFS_MAIN_CONFIG:
                begin
                    prdata_reg[CFG_SCAN] <= scan_reg;
                    prdata_reg[CFG_NORMAL_CHAIN_RUNNING] <= normal_chain_running_reg;
                    prdata_reg[CFG_CANCEL] <= cancel_reg;
                    prdata_reg[CFG_LINK_EN] <= link_en_reg;
                end
                OFS_MAIN_STATUS:
                begin
                    prdata_reg[STS_NRUN] <= nrun;
                    prdata_reg[STS_JRUN] <= |jtodo_reg;
                    prdata_reg[STS_TRUN] <= tpend_reg;
                    prdata_reg[STS_STATE +: 2] <= state_reg;
                end
                OFS_INT_FLAG: prdata_reg[NFLAG-1:0] <= flag_reg;
                OFS_INT_MASK: prdata_reg[NFLAG-1:0] <= imask_reg;
                OFS_NORM_MASK: prdata_reg[NCH-1:0] <= nmask_reg;
                OFS_INJ_MASK: prdata_reg[NCH-1:0] <= jmask_reg;
                OFS_DONE_PEND: prdata_reg[NCH-1:0] <= pend_reg;
                default: prdata_reg <= '0;
            endcase
        end
    end

    // Result words come straight from the store's output register
    assign prdata = res_sel_reg ? {{(32 - RESW){1'b0}}, mem_rdata} : prdata_reg;

endmodule : acs_chain_sequencer

/* File: common/acs_pkg.sv */
package acs_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NCH = 8;                 // Channels in a chain mask
    localparam int CHW = 3;                 // Channel index width
    localparam int RESW = 10;               // Conversion result width
    localparam int AW = 8;                  // Decoded APB address bits

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [AW-1:0] OFS_MAIN_CONFIG = 8'h00;
    localparam logic [AW-1:0] OFS_MAIN_STATUS = 8'h04;
    localparam logic [AW-1:0] OFS_INT_FLAG = 8'h08;
    localparam logic [AW-1:0] OFS_INT_MASK = 8'h0C;
    localparam logic [AW-1:0] OFS_NORM_MASK = 8'h10;
    localparam logic [AW-1:0] OFS_INJ_MASK = 8'h14;
    localparam logic [AW-1:0] OFS_DONE_PEND = 8'h18;
    localparam logic [AW-1:0] OFS_RESULT = 8'h40;   // Channel n at 0x40 + 4*n
    localparam logic [AW-1:0] RESULT_SPAN = 8'h20;

    // ****************************************
    // Main configuration bits
    // ****************************************
    localparam int CFG_SCAN = 0;            // 1 = scan, 0 = one-shot
    localparam int CFG_NORMAL_CHAIN_RUNNING = 1;          // Normal chain start
    localparam int CFG_INJECTED_CHAIN_RUNNING = 2;          // Injected chain start, self clearing
    localparam int CFG_ABORT = 3;           // Abort current channel, self clearing
    localparam int CFG_CANCEL = 4;          // Chain cancel, cleared by hardware
    localparam int CFG_LINK_EN = 5;         // Trigger unit link enable

    // ****************************************
    // Status and interrupt bits
    // ****************************************
    localparam int STS_NRUN = 0;            // Normal chain running
    localparam int STS_JRUN = 1;            // Injected chain running
    localparam int STS_TRUN = 2;            // Trigger unit conversion pending
    localparam int STS_STATE = 4;           // Sequencer state field, 2 bits
    localparam int NFLAG = 3;
    localparam int FLG_ECH = 0;             // Normal end of chain
    localparam int FLG_INJECTED_CHAIN_DONE_FLAG = 1;            // Injected chain done
    localparam int FLG_TEOC = 2;            // Trigger unit conversion done

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SAMPLE = 2'h1,
        ST_CONV = 2'h3,
        ST_ABORT = 2'h2
    } acs_state_t;

    typedef enum logic [1:0] {
        K_NORM = 2'h0,
        K_INJ = 2'h1,
        K_TRIG = 2'h2
    } acs_kind_t;

endpackage : acs_pkg

/* File: logic/acs_result_mem.sv */
`timescale 1ns/1ps
// Small result store, one word per channel, registered read port
module acs_result_mem
    import acs_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Write port
    input wire logic we,
    input wire logic [CHW-1:0] waddr,
    input wire logic [RESW-1:0] wdata,
    // Read port
    input wire logic [CHW-1:0] raddr,
    output logic [RESW-1:0] rdata
);

    // Storage array, no reset needed
    logic [RESW-1:0] mem [NCH];

    // Write on strobe
    always_ff @(posedge pclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // Read data from a register
    always_ff @(posedge pclk)
    begin
        rdata <= mem[raddr];
    end

endmodule : acs_result_mem

/* File: verification/acs_core_model.sv */
`timescale 1ns/1ps
// Converter core stand-in: samples two cycles, converts conv_len+1 cycles
module acs_core_model
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Sequencer side
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic [CHW-1:0] conv_chan,
    // Conversion length, prompt or slow
    input wire logic [3:0] conv_len,
    output logic core_sampling,
    output logic core_done,
    output logic [RESW-1:0] core_data
);
    logic [4:0] cnt_reg; // Cycles left, zero when idle
    // Abort drops the conversion at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 5'h00;
        else if (conv_abort)
            cnt_reg <= 5'h00;
        else if (conv_start)
            cnt_reg <= {1'b0, conv_len} + 5'h03;
        else if (cnt_reg != 5'h00)
            cnt_reg <= cnt_reg - 5'h01;
    end
    assign core_sampling = cnt_reg > ({1'b0, conv_len} + 5'h01);
    // Result with done; data toggles when not valid
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_done <= 1'b0;
        else
            core_done <= (cnt_reg == 5'h01) && !conv_abort;
        if (cnt_reg == 5'h01)
            core_data <= {conv_chan, 7'h55};
        else
            core_data <= ~core_data;
    end
endmodule : acs_core_model

/* File: verification/acs_chain_sequencer_checker.sv */
`timescale 1ns/1ps
// Port checks on the chain sequencer
module acs_chain_sequencer_checker
    import acs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic [CHW-1:0] conv_chan,
    input wire logic core_done
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_acc; // Write in access phase
    assign wr_acc = psel && penable && pwrite;
    a_start_abort_apart: assert property (!(conv_start && conv_abort))
        else $error("start with abort");
    a_start_one_cycle: assert property (conv_start |=> !conv_start)
        else $error("start not a pulse");
    a_abort_one_cycle: assert property (conv_abort |=> !conv_abort)
        else $error("abort not a pulse");
    a_chan_held: assert property (!conv_start |-> $stable(conv_chan))
        else $error("channel moved");
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    a_err_unmapped: assert property (psel && penable && paddr == 8'h1C |-> pslverr)
        else $error("no error on hole");
    a_rdata_held: assert property ($changed(prdata) |-> $past(psel && !penable))
        else $error("read data moved");
    a_irq_cause: assert property ($rose(irq) |->
        $past(core_done) || $past(wr_acc) || $past(wr_acc, 2))
        else $error("irq without cause");
endmodule : acs_chain_sequencer_checker
bind acs_chain_sequencer acs_chain_sequencer_checker acs_chain_sequencer_checker_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
    .irq, .conv_start, .conv_abort, .conv_chan, .core_done);

/* File: verification/acs_chain_sequencer_tb_top.sv */
`timescale 1ns/1ps
// Bench: random and corner chains through the sequencer
module acs_chain_sequencer_tb_top
    import acs_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trig_req = 0;
    logic [AW-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'hF27D99A2;
    logic pready, pslverr, irq, conv_start, conv_abort, core_sampling, core_done;
    logic [CHW-1:0] trig_chan = 3'h0, conv_chan;
    logic [RESW-1:0] core_data;
    logic [3:0] conv_len = 4'h1;
    logic [7:0] m;
    int mismatches = 0, checked = 0, cyc = 0;
    always #25 pclk = ~pclk;
    acs_chain_sequencer acs_chain_sequencer_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .trig_req,
        .trig_chan, .conv_start, .conv_abort, .conv_chan, .core_sampling,
        .core_done, .core_data);
    acs_core_model acs_core_model_inst (.pclk, .presetn, .conv_start, .conv_abort,
        .conv_chan, .conv_len, .core_sampling, .core_done, .core_data);
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    // Start a chain and poll until all running bits drop
    task automatic run(input logic [31:0] cfg);
        apb(1'b1, OFS_MAIN_CONFIG, cfg);
        do apb(1'b0, OFS_MAIN_STATUS, 32'h0); while (rd[2:0] !== 3'h0);
    endtask : run
    task automatic clr(input logic [7:0] nm);
        apb(1'b1, OFS_MAIN_CONFIG, 32'h0);
        apb(1'b1, OFS_DONE_PEND, 32'hFF);
        apb(1'b1, OFS_INT_FLAG, 32'h7);
        apb(1'b1, OFS_NORM_MASK, {24'h0, nm});
    endtask : clr
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            mismatches++;
            end_sim();
        end
    end
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_MAIN_STATUS, 32'h0);
        chk("status", rd, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk("hole", rd, 32'h0);
        // Random one-shot chains, prompt and slow core
        repeat (4)
        begin
            lf = nxt(lf);
            m = lf[7:0] | 8'h01;
            conv_len <= lf[11:8];
            clr(m);
            apb(1'b1, OFS_MAIN_CONFIG, 32'h2);
            run(32'h2);
            apb(1'b0, OFS_DONE_PEND, 32'h0);
            chk("pending", rd, {24'h0, m});
            apb(1'b0, OFS_INT_FLAG, 32'h0);
            chk("flags", rd, 32'h1);
            for (int c = 0; c < NCH; c++)
                if (m[c])
                begin
                    apb(1'b0, OFS_RESULT + 8'(4 * c), 32'h0);
                    chk("result", rd, {22'h0, 3'(c), 7'h55});
                end
        end
        // Injected chain during conversion of channel 1
        conv_len <= 4'h8;
        clr(8'h0F);
        apb(1'b1, OFS_INJ_MASK, 32'h30);
        apb(1'b1, OFS_MAIN_CONFIG, 32'h2);
        @(posedge core_done);
        @(negedge core_sampling);
        apb(1'b1, OFS_MAIN_CONFIG, 32'h4);
        @(posedge conv_start);
        apb(1'b1, OFS_MAIN_CONFIG, 32'h8);
        run(32'h0);
        apb(1'b0, OFS_DONE_PEND, 32'h0);
        chk("preempt pending", rd, 32'h2F);
        apb(1'b0, OFS_INT_FLAG, 32'h0);
        chk("preempt flags", rd, 32'h3);
        // Trigger while the first channel samples
        clr(8'h03);
        apb(1'b1, OFS_MAIN_CONFIG, 32'h22);
        @(posedge core_sampling);
        trig_req <= 1'b1;
        trig_chan <= 3'h7;
        @(posedge pclk);
        trig_req <= 1'b0;
        run(32'h20);
        apb(1'b0, OFS_DONE_PEND, 32'h0);
        chk("trigger pending", rd, 32'h83);
        // Link enable off and on again re-arms triggers
        clr(8'h00);
        apb(1'b1, OFS_MAIN_CONFIG, 32'h20);
        @(posedge pclk);
        trig_req <= 1'b1;
        trig_chan <= 3'h5;
        @(posedge pclk);
        trig_req <= 1'b0;
        run(32'h20);
        apb(1'b0, OFS_DONE_PEND, 32'h0);
        chk("relinked", rd, 32'h20);
        // Chain cancel sets injected done and clears itself
        clr(8'h00);
        apb(1'b1, OFS_MAIN_CONFIG, 32'h4);
        apb(1'b1, OFS_MAIN_CONFIG, 32'h10);
        apb(1'b0, OFS_MAIN_CONFIG, 32'h0);
        chk("cancel bit", {31'h0, rd[CFG_CANCEL]}, 32'h0);
        apb(1'b0, OFS_INT_FLAG, 32'h0);
        chk("cancel flag", rd, 32'h2);
        // Scan keeps running flag through chain end
        clr(8'h01);
        apb(1'b1, OFS_MAIN_CONFIG, 32'h3);
        do apb(1'b0, OFS_INT_FLAG, 32'h0); while (rd[0] !== 1'b1);
        apb(1'b0, OFS_MAIN_STATUS, 32'h0);
        chk("scan running", {31'h0, rd[STS_NRUN]}, 32'h1);
        run(32'h0);
        // Interrupt raised by mask, dropped by clear
        apb(1'b1, OFS_INT_MASK, 32'h1);
        @(negedge pclk);
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b1, OFS_INT_FLAG, 32'h7);
        @(negedge pclk);
        chk("irq off", {31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule : acs_chain_sequencer_tb_top
